/* File: pcdc_pkg.sv */
// Purpose: Shared constants and types for the pin and clock divider configuration block
// Assumes: 8-bit register data, 16-bit register addresses from the serial control port
// Notes:   Power controls and configuration travel as packed structs; power state is an enum
package pcdc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [15:0] ADDR_PIN_OVERRIDE = 16'h003f;
  localparam logic [15:0] ADDR_PIN_FUNC     = 16'h0040;
  localparam logic [15:0] ADDR_DIV_RATIO    = 16'h0108;
  localparam logic [15:0] ADDR_DIV_PHASE    = 16'h0109;

  localparam int unsigned OVR_BIT      = 7;
  localparam int unsigned FUNC_MSB     = 7;
  localparam int unsigned FUNC_LSB     = 6;
  localparam int unsigned FD_SECOND_MSB = 5;
  localparam int unsigned FD_SECOND_LSB = 3;
  localparam int unsigned FD_FIRST_MSB = 2;
  localparam int unsigned FD_FIRST_LSB = 0;
  localparam int unsigned DIV_MSB      = 2;
  localparam int unsigned PHASE_MSB    = 3;

  localparam logic       RST_OVERRIDE = 1'b0;
  localparam logic [1:0] RST_FUNC     = 2'h0;
  localparam logic [2:0] RST_FD_SEL   = 3'h7;
  localparam logic [2:0] RST_DIV_SEL  = 3'h1;
  localparam logic [3:0] RST_PHASE    = 4'h0;

  localparam logic [1:0] FUNC_POWER_DOWN = 2'h0;
  localparam logic [1:0] FUNC_STANDBY    = 2'h1;
  localparam logic [1:0] FUNC_DISABLED   = 2'h2;

  localparam logic [2:0] FD_SRC_FLAG = 3'h0;
  localparam logic [2:0] FD_SRC_LMFC = 3'h1;
  localparam logic [2:0] FD_SRC_SYNC = 3'h2;
  localparam logic [2:0] FD_SRC_OFF  = 3'h7;

  localparam logic [2:0] DIV_BY_1 = 3'h0;
  localparam logic [2:0] DIV_BY_2 = 3'h1;
  localparam logic [2:0] DIV_BY_4 = 3'h3;
  localparam logic [2:0] DIV_BY_8 = 3'h7;

  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned FD_PINS     = 2;

  typedef enum logic [1:0] {PWR_ON, PWR_STANDBY, PWR_DOWN} pcdc_pwr_t;

  typedef struct packed {
    logic       override;
    logic [1:0] pin_func;
    logic [2:0] fd_second_sel;
    logic [2:0] fd_first_sel;
    logic [2:0] div_sel;
    logic [3:0] phase;
  } pcdc_cfg_t;

  typedef struct packed {
    logic dp_clk_en;
    logic dp_rst;
    logic jesd_en;
    logic out_en;
  } pcdc_pwr_ctl_t;
endpackage : pcdc_pkg

/* File: pcdc_divider.sv */
// Purpose: Input clock divider, as a one-cycle enable, with phase offset
// Assumes: Divide codes are all-ones masks, so the terminal count equals the code
// Notes:   Half-cycle steps cannot exist on one edge; the odd bit drives the clock inverter
`timescale 1ns/1ps
`default_nettype none
module pcdc_divider
  import pcdc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic [2:0] i_sel,
  input  wire logic [3:0] i_phase,
  output logic            o_tick,
  output logic            o_clk_inv
);
  import pcdc_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [6:0] dly_q;
  logic [6:0] dly_d;
  logic       raw_tick;
  logic [2:0] idx;

  always_comb begin
    raw_tick = (cnt_q >= i_sel);
    cnt_d    = raw_tick ? 3'h0 : cnt_q + 3'h1;
    dly_d    = {dly_q[5:0], raw_tick};
    idx      = i_phase[PHASE_MSB:1];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_q <= 3'h0;
      dly_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
      dly_q <= dly_d;
    end
  end

  // Whole cycles come from the delay line, the odd half from inverting the input clock
  assign o_tick    = (idx == 3'h0) ? raw_tick : dly_q[idx - 3'h1];
  assign o_clk_inv = i_phase[0];

  sequence s_div4_period;
    (raw_tick && i_sel == DIV_BY_4) ##1 (i_sel == DIV_BY_4)[*4];
  endsequence

  a_div_four_period: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_div4_period |-> raw_tick && !$past(raw_tick) && !$past(raw_tick, 2) && !$past(raw_tick, 3))
    else $error("divide by four period wrong");

  a_div_eight_gap: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (raw_tick && i_sel == DIV_BY_8) ##1 (i_sel == DIV_BY_8)[*7] |-> !$past(raw_tick) ##1 raw_tick)
    else $error("divide by eight period wrong");

  a_phase_delay_three: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_phase[PHASE_MSB:1] == 3'h3) |-> (o_tick == $past(raw_tick, 3)) && (o_clk_inv == i_phase[0]))
    else $error("phase offset delay wrong");
endmodule : pcdc_divider
`default_nettype wire

/* File: pcdc_top.sv */
// Purpose: Power pin, fast detect pin and input clock divider configuration registers
// Assumes: Register requests arrive already decoded from the serial control port
// Notes:   The power pin is asynchronous and is filtered through three flip-flops
`timescale 1ns/1ps
`default_nettype none
module pcdc_top
  import pcdc_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_reg_we,
  input  wire logic                  i_reg_re,
  input  wire logic [ADDR_W-1:0]     i_reg_addr,
  input  wire logic [DATA_W-1:0]     i_reg_wdata,
  output logic      [DATA_W-1:0]     o_reg_rdata,
  output logic                       o_reg_rvalid,
  input  wire logic                  i_power_down_standby_pin,
  input  wire logic [FD_PINS-1:0]    i_detect_flag,
  input  wire logic                  i_lmfc,
  input  wire logic                  i_sync_n,
  output logic      [FD_PINS-1:0]    o_detect_pin_o,
  output logic      [FD_PINS-1:0]    o_detect_pin_oe,
  output logic      [FD_PINS-1:0]    o_detect_pin_pd,
  output var pcdc_pkg::pcdc_pwr_ctl_t o_pwr_ctl,
  output var pcdc_pkg::pcdc_pwr_t    o_pwr_state,
  output logic                       o_div_tick,
  output logic                       o_div_clk_inv
);
  import pcdc_pkg::*;

  // Register file
  pcdc_cfg_t             cfg_q;
  pcdc_cfg_t             cfg_d;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic                  rvalid_q;
  logic                  rvalid_d;

  always_comb begin
    cfg_d    = cfg_q;
    rdata_d  = rdata_q;
    rvalid_d = i_reg_re;
    if (i_reg_we) begin
      unique case (i_reg_addr)
        ADDR_PIN_OVERRIDE: begin
          cfg_d.override = i_reg_wdata[OVR_BIT];
        end
        ADDR_PIN_FUNC: begin
          // Reserved encodings are stored as written; their effect is undefined
          cfg_d.pin_func      = i_reg_wdata[FUNC_MSB:FUNC_LSB];
          cfg_d.fd_second_sel = i_reg_wdata[FD_SECOND_MSB:FD_SECOND_LSB];
          cfg_d.fd_first_sel  = i_reg_wdata[FD_FIRST_MSB:FD_FIRST_LSB];
        end
        ADDR_DIV_RATIO: begin
          cfg_d.div_sel = i_reg_wdata[DIV_MSB:0];
        end
        ADDR_DIV_PHASE: begin
          cfg_d.phase = i_reg_wdata[PHASE_MSB:0];
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
    if (i_reg_re) begin
      unique case (i_reg_addr)
        ADDR_PIN_OVERRIDE: rdata_d = {cfg_q.override, 7'h00};
        ADDR_PIN_FUNC:     rdata_d = {cfg_q.pin_func, cfg_q.fd_second_sel, cfg_q.fd_first_sel};
        ADDR_DIV_RATIO:    rdata_d = {5'h00, cfg_q.div_sel};
        ADDR_DIV_PHASE:    rdata_d = {4'h0, cfg_q.phase};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cfg_q.override      <= RST_OVERRIDE;
      cfg_q.pin_func      <= RST_FUNC;
      cfg_q.fd_second_sel <= RST_FD_SEL;
      cfg_q.fd_first_sel  <= RST_FD_SEL;
      cfg_q.div_sel       <= RST_DIV_SEL;
      cfg_q.phase         <= RST_PHASE;
      rdata_q             <= 8'h00;
      rvalid_q            <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // Power pin synchroniser and filter
  logic [SYNC_STAGES-1:0] sync_q;
  logic [SYNC_STAGES-1:0] sync_d;
  logic                   pin_lvl_q;
  logic                   pin_lvl_d;

  always_comb begin
    sync_d    = {sync_q[SYNC_STAGES-2:0], i_power_down_standby_pin};
    // A change is accepted only once the second and third stages agree
    pin_lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : pin_lvl_q;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      sync_q    <= '0;
      pin_lvl_q <= 1'b0;
    end else begin
      sync_q    <= sync_d;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // Power state
  pcdc_pwr_t     pwr_q;
  pcdc_pwr_t     pwr_d;
  pcdc_pwr_ctl_t ctl_q;
  pcdc_pwr_ctl_t ctl_d;

  always_comb begin
    pwr_d = PWR_ON;
    if (!cfg_q.override && pin_lvl_q) begin
      unique case (cfg_q.pin_func)
        FUNC_POWER_DOWN: pwr_d = PWR_DOWN;
        FUNC_STANDBY:    pwr_d = PWR_STANDBY;
        default:         pwr_d = PWR_ON;
      endcase
    end
    unique case (pwr_d)
      PWR_STANDBY: ctl_d = '{dp_clk_en: 1'b0, dp_rst: 1'b0, jesd_en: 1'b1, out_en: 1'b1};
      PWR_DOWN:    ctl_d = '{dp_clk_en: 1'b0, dp_rst: 1'b1, jesd_en: 1'b0, out_en: 1'b0};
      default:     ctl_d = '{dp_clk_en: 1'b1, dp_rst: 1'b0, jesd_en: 1'b1, out_en: 1'b1};
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pwr_q <= PWR_ON;
      ctl_q <= '{dp_clk_en: 1'b1, dp_rst: 1'b0, jesd_en: 1'b1, out_en: 1'b1};
    end else begin
      pwr_q <= pwr_d;
      ctl_q <= ctl_d;
    end
  end

  assign o_pwr_state = pwr_q;
  assign o_pwr_ctl   = ctl_q;

  // Fast detect pin routing
  logic [FD_PINS-1:0] fd_o_q;
  logic [FD_PINS-1:0] fd_o_d;
  logic [FD_PINS-1:0] fd_oe_q;
  logic [FD_PINS-1:0] fd_oe_d;
  logic [2:0]         fd_sel [FD_PINS];

  assign fd_sel[0] = cfg_q.fd_first_sel;
  assign fd_sel[1] = cfg_q.fd_second_sel;

  genvar gi;
  generate
    for (gi = 0; gi < FD_PINS; gi++) begin : g_fd
      always_comb begin
        unique case (fd_sel[gi])
          FD_SRC_FLAG: begin
            fd_o_d[gi]  = i_detect_flag[gi];
            fd_oe_d[gi] = 1'b1;
          end
          FD_SRC_LMFC: begin
            fd_o_d[gi]  = i_lmfc;
            fd_oe_d[gi] = 1'b1;
          end
          FD_SRC_SYNC: begin
            fd_o_d[gi]  = i_sync_n;
            fd_oe_d[gi] = 1'b1;
          end
          default: begin
            // Reserved codes release the pin like the disable code does
            fd_o_d[gi]  = 1'b0;
            fd_oe_d[gi] = 1'b0;
          end
        endcase
      end

      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          fd_o_q[gi]  <= 1'b0;
          fd_oe_q[gi] <= 1'b0;
        end else begin
          fd_o_q[gi]  <= fd_o_d[gi];
          fd_oe_q[gi] <= fd_oe_d[gi];
        end
      end

      a_fd_flag_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (fd_sel[gi] == FD_SRC_FLAG) |=> o_detect_pin_oe[gi] && (o_detect_pin_o[gi] == $past(i_detect_flag[gi])))
        else $error("detect pin does not carry detect flag");

      a_fd_lmfc_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (fd_sel[gi] == FD_SRC_LMFC) |=> o_detect_pin_oe[gi] && (o_detect_pin_o[gi] == $past(i_lmfc)))
        else $error("detect pin does not carry frame clock");

      a_fd_sync_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (fd_sel[gi] == FD_SRC_SYNC) |=> o_detect_pin_oe[gi] && (o_detect_pin_o[gi] == $past(i_sync_n)))
        else $error("detect pin does not carry internal sync");

      a_fd_disabled_pin: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (fd_sel[gi] == FD_SRC_OFF) |=> !o_detect_pin_oe[gi] && o_detect_pin_pd[gi])
        else $error("disabled detect pin still driven");
    end
  endgenerate

  assign o_detect_pin_o  = fd_o_q;
  assign o_detect_pin_oe = fd_oe_q;
  assign o_detect_pin_pd = ~fd_oe_q;

  // Input clock divider
  pcdc_divider u_divider (
    .i_mclk    (i_mclk),
    .i_rstn    (i_rstn),
    .i_sel     (cfg_q.div_sel),
    .i_phase   (cfg_q.phase),
    .o_tick    (o_div_tick),
    .o_clk_inv (o_div_clk_inv)
  );

  // Checks on the power pin path
  sequence s_pin_held;
    pin_lvl_q && !cfg_q.override;
  endsequence

  a_override_ignores_pin: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    cfg_q.override |=> (pwr_q == PWR_ON) && o_pwr_ctl.dp_clk_en)
    else $error("power pin acted while overridden");

  a_pin_release_on: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (!cfg_q.override && !pin_lvl_q) |=> pwr_q == PWR_ON)
    else $error("chip not powered with pin released");

  a_pin_full_down: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (s_pin_held and (cfg_q.pin_func == FUNC_POWER_DOWN)) |=> pwr_q == PWR_DOWN)
    else $error("power pin did not power down");

  a_pin_standby: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (s_pin_held and (cfg_q.pin_func == FUNC_STANDBY)) |=> pwr_q == PWR_STANDBY)
    else $error("power pin did not enter standby");

  a_pin_ignored: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (s_pin_held and (cfg_q.pin_func == FUNC_DISABLED)) |=> pwr_q == PWR_ON)
    else $error("disabled power pin changed state");

  a_standby_outputs: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (pwr_q == PWR_STANDBY) |-> !o_pwr_ctl.dp_clk_en && !o_pwr_ctl.dp_rst && o_pwr_ctl.jesd_en && o_pwr_ctl.out_en)
    else $error("standby controls wrong");

  a_powerdown_outputs: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (pwr_q == PWR_DOWN) |-> !o_pwr_ctl.dp_clk_en && o_pwr_ctl.dp_rst && !o_pwr_ctl.jesd_en && !o_pwr_ctl.out_en)
    else $error("power-down controls wrong");

  a_pin_filter_agree: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $changed(pin_lvl_q) |-> $past(sync_q[1]) == $past(sync_q[2]))
    else $error("pin level changed without agreement");

  a_pin_to_down_delay: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ($rose(sync_q[2]) && sync_q[1] && cfg_q.pin_func == FUNC_POWER_DOWN && !cfg_q.override)[*1]
      ##1 (cfg_q.pin_func == FUNC_POWER_DOWN && !cfg_q.override && sync_q[2]) |=> pwr_q == PWR_DOWN)
    else $error("power pin edge not followed by power-down");

  // Register writes land at the strobe edge, so the field is visible one cycle later
  a_override_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_reg_we && i_reg_addr == ADDR_PIN_OVERRIDE) |=> cfg_q.override == $past(i_reg_wdata[OVR_BIT]))
    else $error("override bit not stored");

  a_func_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_reg_we && i_reg_addr == ADDR_PIN_FUNC) |=> cfg_q.pin_func == $past(i_reg_wdata[FUNC_MSB:FUNC_LSB]))
    else $error("pin function field not stored");

  a_div_sel_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_reg_we && i_reg_addr == ADDR_DIV_RATIO) |=> cfg_q.div_sel == $past(i_reg_wdata[DIV_MSB:0]))
    else $error("divider select not stored");

  a_phase_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_reg_we && i_reg_addr == ADDR_DIV_PHASE) |=> cfg_q.phase == $past(i_reg_wdata[PHASE_MSB:0]))
    else $error("divider phase not stored");
endmodule : pcdc_top
`default_nettype wire

/* File: pcdc_host.sv */
// Purpose: Host software model that drives the register port
// Assumes: Requests change 1 ns after the rising edge and hold for one edge
// Notes:   Reserved pin function and divide codes are dropped here instead of being sent
`timescale 1ns/1ps
`default_nettype none
module pcdc_host
  import pcdc_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic [DATA_W-1:0] i_reg_rdata,
  input  wire logic              i_reg_rvalid,
  output logic                   o_reg_we,
  output logic                   o_reg_re,
  output logic      [ADDR_W-1:0] o_reg_addr,
  output logic      [DATA_W-1:0] o_reg_wdata
);
  initial begin
    o_reg_we = 1'b0;
    o_reg_re = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 8'h00;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    if (a == ADDR_PIN_FUNC && d[7:6] == 2'h3) return;
    if (a == ADDR_DIV_RATIO && !(d[2:0] inside {DIV_BY_1, DIV_BY_2, DIV_BY_4, DIV_BY_8})) return;
    @(posedge i_mclk);
    #1;
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_we = 1'b1;
    @(posedge i_mclk);
    #1;
    o_reg_we = 1'b0;
  endtask : wr

  // Answer is due at the same edge that takes the strobe, one edge after it is raised
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_mclk);
    #1;
    o_reg_addr = a;
    o_reg_re = 1'b1;
    @(posedge i_mclk);
    #1;
    o_reg_re = 1'b0;
    ok = (i_reg_rvalid === 1'b1);
    d = i_reg_rdata;
  endtask : rd
endmodule : pcdc_host
`default_nettype wire

/* File: pcdc_top_tb.sv */
// Purpose: Self-checking bench for the pin and clock divider configuration block
// Assumes: Inputs change 1 ns after the rising edge; outputs sampled there too
// Notes:   Divider phase is judged against a free cycle count, since it never resyncs
`timescale 1ns/1ps
`default_nettype none
module pcdc_top_tb;
  import pcdc_pkg::*;
  logic                clk;
  logic                rstn;
  logic                we;
  logic                re;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;
  logic                rvalid;
  logic                pin;
  logic [1:0]          flag;
  logic                lmfc;
  logic                sync_n;
  logic [1:0]          det_o;
  logic [1:0]          det_oe;
  logic [1:0]          det_pd;
  pcdc_pwr_ctl_t       pwr_ctl;
  pcdc_pwr_t           pwr_st;
  logic                tick;
  logic                inv;
  int                  errors;
  int                  n_compared;
  int                  cyc;

  pcdc_top i_dut (.i_mclk(clk), .i_rstn(rstn), .i_reg_we(we), .i_reg_re(re), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_power_down_standby_pin(pin),
    .i_detect_flag(flag), .i_lmfc(lmfc), .i_sync_n(sync_n), .o_detect_pin_o(det_o),
    .o_detect_pin_oe(det_oe), .o_detect_pin_pd(det_pd), .o_pwr_ctl(pwr_ctl), .o_pwr_state(pwr_st),
    .o_div_tick(tick), .o_div_clk_inv(inv));
  pcdc_host i_host (.i_mclk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_we(we),
    .o_reg_re(re), .o_reg_addr(addr), .o_reg_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host.rd(a, d, ok);
    chk("rvalid", {7'h0, ok}, 8'h01);
    chk("rdata", d, exp);
  endtask : rdchk

  task automatic t_reset;
    chk("oe", {6'h0, det_oe}, 8'h00);
    chk("pd", {6'h0, det_pd}, 8'h03);
    chk("state", {6'h0, pwr_st}, {6'h0, PWR_ON});
    rdchk(ADDR_PIN_OVERRIDE, 8'h00);
    rdchk(ADDR_PIN_FUNC, 8'h3f);
    rdchk(ADDR_DIV_RATIO, 8'h01);
    rdchk(ADDR_DIV_PHASE, 8'h00);
  endtask : t_reset

  // Read-only bits must drop on write; an unmapped write must touch nothing
  task automatic t_regs;
    i_host.wr(ADDR_PIN_OVERRIDE, 8'hff);
    rdchk(ADDR_PIN_OVERRIDE, 8'h80);
    i_host.wr(ADDR_DIV_PHASE, 8'hff);
    rdchk(ADDR_DIV_PHASE, 8'h0f);
    i_host.wr(ADDR_DIV_RATIO, 8'hff);
    rdchk(ADDR_DIV_RATIO, 8'h07);
    i_host.wr(16'h0041, 8'h00);
    rdchk(16'h0041, 8'h00);
    rdchk(ADDR_PIN_FUNC, 8'h3f);
    i_host.wr(ADDR_PIN_OVERRIDE, 8'h00);
    // Phase back to zero, so later tick counts and phase steps start from no delay
    i_host.wr(ADDR_DIV_PHASE, 8'h00);
    rdchk(ADDR_DIV_PHASE, 8'h00);
  endtask : t_regs

  function automatic logic src(input logic [2:0] s, input int k);
    if (s == FD_SRC_FLAG) return flag[k];
    if (s == FD_SRC_LMFC) return lmfc;
    if (s == FD_SRC_SYNC) return sync_n;
    return 1'b0;
  endfunction : src

  task automatic t_detect;
    logic [2:0] sels [4] = '{FD_SRC_FLAG, FD_SRC_LMFC, FD_SRC_SYNC, FD_SRC_OFF};
    logic [2:0] s1;
    logic [2:0] s0;
    logic [1:0] eoe;
    for (int i = 0; i < 4; i++) begin
      s1 = sels[i];
      s0 = sels[(i + 1) % 4];
      i_host.wr(ADDR_PIN_FUNC, {2'h0, s1, s0});
      for (int p = 0; p < 8; p++) begin
        flag = p[1:0];
        lmfc = p[2];
        sync_n = p[0] ^ p[2];
        repeat (2) @(posedge clk);
        #1;
        eoe = {s1 != FD_SRC_OFF, s0 != FD_SRC_OFF};
        chk("oe", {6'h0, det_oe}, {6'h0, eoe});
        chk("pd", {6'h0, det_pd}, {6'h0, ~eoe});
        chk("o", {6'h0, det_o & eoe}, {6'h0, {src(s1, 1), src(s0, 0)} & eoe});
      end
    end
  endtask : t_detect

  task automatic t_pwr(input logic ovr, input logic [1:0] fn, input pcdc_pwr_t st, input logic [3:0] ctl);
    i_host.wr(ADDR_PIN_OVERRIDE, {ovr, 7'h0});
    i_host.wr(ADDR_PIN_FUNC, {fn, 6'h3f});
    pin = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("state", {6'h0, pwr_st}, {6'h0, st});
    chk("ctl", {4'h0, pwr_ctl}, {4'h0, ctl});
    pin = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("state", {6'h0, pwr_st}, {6'h0, PWR_ON});
    chk("ctl", {4'h0, pwr_ctl}, 8'h0b);
  endtask : t_pwr

  task automatic first_tick(output int p);
    p = -1;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1 && p < 0) p = cyc % 8;
    end
  endtask : first_tick

  task automatic t_div;
    logic [2:0] codes [4] = '{DIV_BY_1, DIV_BY_2, DIV_BY_4, DIV_BY_8};
    int n;
    int p0;
    int p6;
    int p7;
    foreach (codes[i]) begin
      i_host.wr(ADDR_DIV_RATIO, {5'h0, codes[i]});
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16) begin
        @(posedge clk);
        #1;
        if (tick === 1'b1) n++;
      end
      chk("ticks", 8'(n), 8'(16 / (codes[i] + 1)));
    end
    first_tick(p0);
    i_host.wr(ADDR_DIV_PHASE, 8'h06);
    repeat (10) @(posedge clk);
    first_tick(p6);
    chk("phase6", 8'(p6), 8'((p0 + 3) % 8));
    chk("inv6", {7'h0, inv}, 8'h00);
    i_host.wr(ADDR_DIV_PHASE, 8'h07);
    repeat (10) @(posedge clk);
    first_tick(p7);
    chk("phase7", 8'(p7), 8'(p6));
    chk("inv7", {7'h0, inv}, 8'h01);
  endtask : t_div

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    pin = 1'b0;
    flag = 2'h0;
    lmfc = 1'b0;
    sync_n = 1'b1;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_detect();
    t_pwr(1'b0, FUNC_POWER_DOWN, PWR_DOWN, 4'h4);
    t_pwr(1'b0, FUNC_STANDBY, PWR_STANDBY, 4'h3);
    t_pwr(1'b0, FUNC_DISABLED, PWR_ON, 4'hb);
    t_pwr(1'b1, FUNC_POWER_DOWN, PWR_ON, 4'hb);
    t_pwr(1'b1, FUNC_STANDBY, PWR_ON, 4'hb);
    t_div();
    end_sim();
  end
endmodule : pcdc_top_tb
`default_nettype wire
